// *** verilog/ucfb_consts.svh ***
// constants of the serial to CAN filter and pair bridge
`ifndef UCFB_CONSTS_SVH
`define UCFB_CONSTS_SVH
`define UCFB_CLK_MHZ 25
`define UCFB_MS_US 1000
`define UCFB_MS_CYCLES (`UCFB_MS_US * `UCFB_CLK_MHZ)
`define UCFB_ERR_MS 9'd300
`define UCFB_CTRL_OFS 5'h00
`define UCFB_CODE_OFS 5'h04
`define UCFB_MASK_OFS 5'h08
`define UCFB_TXID_OFS 5'h0c
`define UCFB_TERM_OFS 5'h10
`define UCFB_TMO_OFS 5'h14
`define UCFB_STAT_OFS 5'h18
`define UCFB_CTRL_PAIR 0
`define UCFB_CTRL_EXT 1
`define UCFB_CTRL_FIXID 2
`define UCFB_CTRL_RESPID 3
`define UCFB_CTRL_TERM_LSB 4
`define UCFB_CTRL_RST 7'h00
`define UCFB_TERM_RST 16'h0d0a
`define UCFB_TMO_RST 16'h0301
`define UCFB_STD_ID_W 11
`define UCFB_EXT_ID_W 29
`define UCFB_BUF_DEPTH 7'd72
`define UCFB_MAX_DLC 4'd8
`define UCFB_HDR_CHARS 2'd3
`define UCFB_CR 8'h0d
`define UCFB_LF 8'h0a
`endif

// *** verilog/ucfb_pkg.sv ***
// types of the serial to CAN filter and pair bridge
`default_nettype none
package ucfb_pkg;
   typedef enum logic [1:0]
   {
      RX_IDLE  = 2'b00,
      RX_COPY  = 2'b01,
      RX_PFX   = 2'b10,
      RX_DRAIN = 2'b11
   } ucfb_rx_state_t;

   typedef enum logic [2:0]
   {
      TERM_NONE = 3'b000,
      TERM_CR   = 3'b001,
      TERM_LF   = 3'b010,
      TERM_CRLF = 3'b011,
      TERM_LFCR = 3'b100,
      TERM_USER = 3'b101
   } ucfb_term_t;

   typedef enum logic
   {
      PK_FILL = 1'b0,
      PK_SEND = 1'b1
   } ucfb_pk_state_t;
endpackage : ucfb_pkg
`default_nettype wire

// *** verilog/ucfb_accept_filter.sv ***
// acceptance code and mask comparison of received identifiers
`timescale 1ns/1ps
`default_nettype none
`include "ucfb_consts.svh"
module ucfb_accept_filter
(
   input  wire logic [28:0] id,
   input  wire logic [28:0] code,
   input  wire logic [28:0] mask,
   input  wire logic        ext,
   output logic             pass
);
   logic [28:0] miss;

   // per bit mismatch, only where masked and inside the format width
   genvar i;
   generate
      for (i = 0; i < `UCFB_EXT_ID_W; i = i + 1)
      begin : gBit
         assign miss[i] = mask[i] & (id[i] ^ code[i])
                        & ((i < `UCFB_STD_ID_W) | ext);
      end
   endgenerate

   assign pass = ~|miss;
endmodule : ucfb_accept_filter
`default_nettype wire

// *** verilog/ucfb_tx_packer.sv ***
// packs serial bytes into CAN frames for pair connection
`timescale 1ns/1ps
`default_nettype none
`include "ucfb_consts.svh"
module ucfb_tx_packer
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        clr,
   input  wire logic        en,
   input  wire logic        ext,
   input  wire logic        fixedEn,
   input  wire logic [28:0] fixedId,
   input  wire logic [7:0]  tmoMs,
   input  wire logic        msTick,
   input  wire logic        inValid,
   input  wire logic [7:0]  inData,
   output logic             inReady,
   output logic             outValid,
   output logic [28:0]      outId,
   output logic [3:0]       outDlc,
   output logic [63:0]      outData,
   input  wire logic        outReady
);
   ucfb_pkg::ucfb_pk_state_t stateReg;
   logic [1:0]  hdrCntReg;
   logic [11:0] dynIdReg;
   logic [3:0]  cntReg;
   logic [63:0] dataReg;
   logic [7:0]  idleMsReg;
   logic        take;
   logic        inHdr;
   logic [7:0]  lowChar;
   logic [3:0]  nib;
   logic        tmoHit;
   logic [28:0] idSel;

   // hex character to nibble and identifier choice
   assign take    = inValid & inReady;
   assign inHdr   = ~fixedEn & (hdrCntReg != `UCFB_HDR_CHARS);
   assign lowChar = inData | 8'h20;
   assign nib     = (inData <= 8'h39) ? 4'(inData - 8'h30) : 4'(lowChar - 8'h57);
   assign tmoHit  = msTick & ((idleMsReg + 8'h01) >= tmoMs);
   assign idSel   = fixedEn ? fixedId : {17'h0000, dynIdReg};
   // fill, send on eight bytes or serial timeout
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stateReg  <= ucfb_pkg::PK_FILL;
         hdrCntReg <= 2'h0;
         dynIdReg  <= 12'h000;
         cntReg    <= 4'h0;
         dataReg   <= 64'h0;
         idleMsReg <= 8'h00;
         inReady   <= 1'b0;
         outValid  <= 1'b0;
         outId     <= 29'h0;
         outDlc    <= 4'h0;
         outData   <= 64'h0;
      end
      else if (ce)
      begin
         if (clr | ~en)
         begin
            stateReg  <= ucfb_pkg::PK_FILL;
            hdrCntReg <= 2'h0;
            cntReg    <= 4'h0;
            dataReg   <= 64'h0;
            idleMsReg <= 8'h00;
            inReady   <= 1'b0;
            outValid  <= 1'b0;
         end
         else
         begin
            case (stateReg)
               ucfb_pkg::PK_FILL:
               begin
                  inReady <= 1'b1;
                  if (take)
                  begin
                     idleMsReg <= 8'h00;
                     if (inHdr)
                     begin
                        dynIdReg  <= {dynIdReg[7:0], nib};
                        hdrCntReg <= hdrCntReg + 2'h1;
                     end
                     else
                     begin
                        dataReg[cntReg[2:0]*8 +: 8] <= inData;
                        cntReg <= cntReg + 4'h1;
                        if (cntReg == `UCFB_MAX_DLC - 4'h1)
                        begin
                           stateReg <= ucfb_pkg::PK_SEND;
                           inReady  <= 1'b0;
                        end
                     end
                  end
                  else if (msTick & ((cntReg != 4'h0) | (hdrCntReg != 2'h0)))
                  begin
                     idleMsReg <= idleMsReg + 8'h01;
                     if (tmoHit)
                     begin
                        idleMsReg <= 8'h00;
                        hdrCntReg <= 2'h0;
                        if (cntReg != 4'h0)
                        begin
                           stateReg <= ucfb_pkg::PK_SEND;
                           inReady  <= 1'b0;
                        end
                     end
                  end
               end
               ucfb_pkg::PK_SEND:
               begin
                  if (~outValid)
                  begin
                     outValid <= 1'b1;
                     outId    <= ext ? idSel : {18'h00000, idSel[10:0]};
                     outDlc   <= cntReg;
                     outData  <= dataReg;
                  end
                  else if (outReady)
                  begin
                     outValid <= 1'b0;
                     cntReg   <= 4'h0;
                     dataReg  <= 64'h0;
                     stateReg <= ucfb_pkg::PK_FILL;
                     inReady  <= 1'b1;
                  end
               end
               default:
                  stateReg <= ucfb_pkg::PK_FILL;
            endcase
         end
      end
   end
endmodule : ucfb_tx_packer
`default_nettype wire

// *** verilog/ucfb_bridge.sv ***
// top: registers, receive filter, serial output buffer and error restart
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ucfb_consts.svh"
module ucfb_bridge
#(
   parameter int unsigned MS_CYCLES = `UCFB_MS_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        serRxValid,
   input  wire logic [7:0]  serRxData,
   output logic             serRxReady,
   output logic             serTxValid,
   output logic [7:0]       serTxData,
   input  wire logic        serTxReady,
   input  wire logic        canRxValid,
   input  wire logic [28:0] canRxId,
   input  wire logic [3:0]  canRxDlc,
   input  wire logic [63:0] canRxData,
   output logic             canRxReady,
   output logic             canTxValid,
   output logic [28:0]      canTxId,
   output logic             canTxExt,
   output logic [3:0]       canTxDlc,
   output logic [63:0]      canTxData,
   input  wire logic        canTxReady,
   output logic             errLed,
   output logic             restartPulse
);
   logic [6:0]  ctrlReg;
   logic [28:0] codeReg;
   logic [28:0] maskReg;
   logic [28:0] txIdReg;
   logic [15:0] termReg;
   logic [15:0] tmoReg;
   logic [7:0]  dropCntReg;
   logic [31:0] beMask;
   logic        req;
   logic        wrEn;
   logic [31:0] rdMux;
   logic        pairEn;
   logic        extFmt;
   logic        respId;
   logic [2:0]  termSel;
   logic        termNone;

   // register decode and byte lane merge
   assign req      = avs_read | avs_write;
   assign wrEn     = avs_write & ~avs_waitrequest;
   assign beMask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign pairEn   = ctrlReg[`UCFB_CTRL_PAIR];
   assign extFmt   = ctrlReg[`UCFB_CTRL_EXT];
   assign respId   = ctrlReg[`UCFB_CTRL_RESPID];
   assign termSel  = ctrlReg[`UCFB_CTRL_TERM_LSB +: 3];
   assign termNone = (termSel == ucfb_pkg::TERM_NONE);

   function automatic logic [31:0] mrg(input logic [31:0] old);
      mrg = (old & ~beMask) | (avs_writedata & beMask);
   endfunction : mrg

   // bus handshake: one wait cycle, write lands when waitrequest is low
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end
      else if (ce)
      begin
         if (req & avs_waitrequest)
         begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rdMux;
         end
         else
         begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrlReg <= `UCFB_CTRL_RST;
         codeReg <= 29'h0;
         maskReg <= 29'h0;
         txIdReg <= 29'h0;
         termReg <= `UCFB_TERM_RST;
         tmoReg  <= `UCFB_TMO_RST;
      end
      else if (ce & wrEn)
      begin
         case (avs_address)
            `UCFB_CTRL_OFS: ctrlReg <= 7'(mrg({25'h0, ctrlReg}));
            `UCFB_CODE_OFS: codeReg <= 29'(mrg({3'h0, codeReg}));
            `UCFB_MASK_OFS: maskReg <= 29'(mrg({3'h0, maskReg}));
            `UCFB_TXID_OFS: txIdReg <= 29'(mrg({3'h0, txIdReg}));
            `UCFB_TERM_OFS: termReg <= 16'(mrg({16'h0, termReg}));
            `UCFB_TMO_OFS:  tmoReg  <= 16'(mrg({16'h0, tmoReg}));
            default:        ctrlReg <= ctrlReg;
         endcase
      end
   end

   // millisecond tick shared by timeouts and error lamp
   logic [31:0] msCntReg;
   logic        msTickReg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         msCntReg  <= 32'h0;
         msTickReg <= 1'b0;
      end
      else if (ce)
      begin
         msTickReg <= (msCntReg == 32'(MS_CYCLES - 1));
         msCntReg  <= (msCntReg == 32'(MS_CYCLES - 1)) ? 32'h0 : msCntReg + 32'h1;
      end
   end

   // receive path state
   ucfb_pkg::ucfb_rx_state_t rxState;
   logic [7:0]  bufMem [0:71];
   logic [6:0]  bufCntReg;
   logic [6:0]  rdIdxReg;
   logic [63:0] frmDataReg;
   logic [3:0]  frmLeftReg;
   logic [11:0] pfxIdReg;
   logic [1:0]  pfxCntReg;
   logic [7:0]  prevReg;
   logic        flushReg;
   logic [7:0]  canIdleReg;
   logic        errReg;
   logic [8:0]  errMsReg;
   logic        clrDp;
   logic        idPass;
   logic        rxTake;
   logic [7:0]  curByte;
   logic        termHit;
   logic        ovf;
   logic        outFree;
   logic [3:0]  pfxNib;
   logic [7:0]  pfxChar;
   logic        canTmoHit;
   logic [3:0]  dlcClip;
   logic        lastOut;

   ucfb_accept_filter uFilter
   (
      .id   (canRxId),
      .code (codeReg),
      .mask (maskReg),
      .ext  (extFmt),
      .pass (idPass)
   );

   // frame intake, terminator check, hex prefix and timeout terms
   assign clrDp     = restartPulse;
   assign rxTake    = canRxValid & canRxReady;
   assign curByte   = frmDataReg[7:0];
   assign ovf       = (rxState == ucfb_pkg::RX_COPY) & (frmLeftReg != 4'h0)
                    & (bufCntReg == `UCFB_BUF_DEPTH);
   assign termHit   = (termSel == ucfb_pkg::TERM_CR   & curByte == `UCFB_CR)
                    | (termSel == ucfb_pkg::TERM_LF   & curByte == `UCFB_LF)
                    | (termSel == ucfb_pkg::TERM_CRLF & prevReg == `UCFB_CR & curByte == `UCFB_LF)
                    | (termSel == ucfb_pkg::TERM_LFCR & prevReg == `UCFB_LF & curByte == `UCFB_CR)
                    | (termSel == ucfb_pkg::TERM_USER & prevReg == termReg[15:8]
                       & curByte == termReg[7:0]);
   assign outFree   = ~serTxValid | serTxReady;
   assign pfxNib    = pfxIdReg[4'(pfxCntReg) * 4'h4 +: 4];
   assign pfxChar   = (pfxNib < 4'ha) ? 8'h30 + {4'h0, pfxNib} : 8'h37 + {4'h0, pfxNib};
   assign canTmoHit = msTickReg & ((canIdleReg + 8'h01) >= tmoReg[7:0]);
   assign dlcClip   = (canRxDlc > `UCFB_MAX_DLC) ? `UCFB_MAX_DLC : canRxDlc;
   assign lastOut   = (rdIdxReg + 7'h01) == bufCntReg;

   // count of filtered-out frames for status
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         dropCntReg <= 8'h00;
      else if (ce & rxTake & ~idPass)
         dropCntReg <= dropCntReg + 8'h01;
   end

   // buffer write during copy
   always_ff @(posedge clk)
   begin
      if (ce & (rxState == ucfb_pkg::RX_COPY) & (frmLeftReg != 4'h0) & ~ovf)
         bufMem[bufCntReg] <= curByte;
   end

   // receive sequencer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rxState    <= ucfb_pkg::RX_IDLE;
         bufCntReg  <= 7'h00;
         rdIdxReg   <= 7'h00;
         frmDataReg <= 64'h0;
         frmLeftReg <= 4'h0;
         pfxIdReg   <= 12'h000;
         pfxCntReg  <= 2'h0;
         prevReg    <= 8'h00;
         flushReg   <= 1'b0;
         canIdleReg <= 8'h00;
         canRxReady <= 1'b0;
         serTxValid <= 1'b0;
         serTxData  <= 8'h00;
      end
      else if (ce)
      begin
         if (serTxReady)
            serTxValid <= 1'b0;
         if (clrDp | errReg)
         begin
            rxState    <= ucfb_pkg::RX_IDLE;
            bufCntReg  <= 7'h00;
            rdIdxReg   <= 7'h00;
            flushReg   <= 1'b0;
            canRxReady <= 1'b0;
            serTxValid <= 1'b0;
         end
         else
         begin
            case (rxState)
               ucfb_pkg::RX_IDLE:
               begin
                  canRxReady <= ~rxTake;
                  if (msTickReg & (bufCntReg != 7'h00))
                     canIdleReg <= canIdleReg + 8'h01;
                  if (rxTake & idPass & pairEn)
                  begin
                     canIdleReg <= 8'h00;
                     frmDataReg <= canRxData;
                     frmLeftReg <= dlcClip;
                     if (bufCntReg == 7'h00)
                        pfxIdReg <= canRxId[11:0];
                     rxState <= ucfb_pkg::RX_COPY;
                  end
                  else if (~rxTake & canTmoHit & (bufCntReg != 7'h00))
                  begin
                     canIdleReg <= 8'h00;
                     canRxReady <= 1'b0;
                     pfxCntReg  <= `UCFB_HDR_CHARS - 2'h1;
                     rxState    <= respId ? ucfb_pkg::RX_PFX : ucfb_pkg::RX_DRAIN;
                  end
               end
               ucfb_pkg::RX_COPY:
               begin
                  if (frmLeftReg != 4'h0)
                  begin
                     bufCntReg  <= bufCntReg + 7'h01;
                     prevReg    <= curByte;
                     frmDataReg <= {8'h00, frmDataReg[63:8]};
                     frmLeftReg <= frmLeftReg - 4'h1;
                     if (termHit)
                        flushReg <= 1'b1;
                  end
                  else if ((termNone | flushReg) & (bufCntReg != 7'h00))
                  begin
                     flushReg  <= 1'b0;
                     pfxCntReg <= `UCFB_HDR_CHARS - 2'h1;
                     rxState   <= respId ? ucfb_pkg::RX_PFX : ucfb_pkg::RX_DRAIN;
                  end
                  else
                  begin
                     canRxReady <= 1'b1;
                     rxState    <= ucfb_pkg::RX_IDLE;
                  end
               end
               ucfb_pkg::RX_PFX:
               begin
                  if (outFree)
                  begin
                     serTxValid <= 1'b1;
                     serTxData  <= pfxChar;
                     pfxCntReg  <= pfxCntReg - 2'h1;
                     if (pfxCntReg == 2'h0)
                        rxState <= ucfb_pkg::RX_DRAIN;
                  end
               end
               ucfb_pkg::RX_DRAIN:
               begin
                  if (outFree)
                  begin
                     serTxValid <= 1'b1;
                     serTxData  <= bufMem[rdIdxReg];
                     rdIdxReg   <= rdIdxReg + 7'h01;
                     if (lastOut)
                     begin
                        rdIdxReg   <= 7'h00;
                        bufCntReg  <= 7'h00;
                        canRxReady <= 1'b1;
                        rxState    <= ucfb_pkg::RX_IDLE;
                     end
                  end
               end
               default:
                  rxState <= ucfb_pkg::RX_IDLE;
            endcase
         end
      end
   end

   // overflow lamp for 300 ms, then one restart pulse
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         errReg       <= 1'b0;
         errMsReg     <= 9'h000;
         errLed       <= 1'b0;
         restartPulse <= 1'b0;
      end
      else if (ce)
      begin
         restartPulse <= 1'b0;
         if (ovf & ~errReg)
         begin
            errReg   <= 1'b1;
            errLed   <= 1'b1;
            errMsReg <= 9'h000;
         end
         else if (errReg & msTickReg)
         begin
            errMsReg <= errMsReg + 9'h001;
            if (errMsReg == `UCFB_ERR_MS - 9'h001)
            begin
               errReg       <= 1'b0;
               errLed       <= 1'b0;
               restartPulse <= 1'b1;
            end
         end
      end
   end

   // status and read mux
   assign rdMux = (avs_address == `UCFB_CTRL_OFS) ? {25'h0, ctrlReg}
                : (avs_address == `UCFB_CODE_OFS) ? {3'h0, codeReg}
                : (avs_address == `UCFB_MASK_OFS) ? {3'h0, maskReg}
                : (avs_address == `UCFB_TXID_OFS) ? {3'h0, txIdReg}
                : (avs_address == `UCFB_TERM_OFS) ? {16'h0, termReg}
                : (avs_address == `UCFB_TMO_OFS)  ? {16'h0, tmoReg}
                : (avs_address == `UCFB_STAT_OFS) ? {8'h00, dropCntReg, 1'b0, bufCntReg,
                                                     5'h00, rxState, errReg}
                : 32'h0;

   // transmit packer
   ucfb_tx_packer uPacker
   (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .clr      (clrDp | errReg),
      .en       (pairEn),
      .ext      (extFmt),
      .fixedEn  (ctrlReg[`UCFB_CTRL_FIXID]),
      .fixedId  (txIdReg),
      .tmoMs    (tmoReg[15:8]),
      .msTick   (msTickReg),
      .inValid  (serRxValid),
      .inData   (serRxData),
      .inReady  (serRxReady),
      .outValid (canTxValid),
      .outId    (canTxId),
      .outDlc   (canTxDlc),
      .outData  (canTxData),
      .outReady (canTxReady)
   );

   // frame format flag follows configuration
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         canTxExt <= 1'b0;
      else if (ce)
         canTxExt <= extFmt;
   end
endmodule : ucfb_bridge
`default_nettype wire

// *** bench/ucfb_bridge_checker.sv ***
// port assertions of the bridge
`timescale 1ns/1ps
`default_nettype none
module ucfb_bridge_checker
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        canRxValid,
   input wire logic        canRxReady,
   input wire logic        canTxValid,
   input wire logic        canTxReady,
   input wire logic        canTxExt,
   input wire logic [28:0] canTxId,
   input wire logic [3:0]  canTxDlc,
   input wire logic        serRxReady,
   input wire logic        serTxValid,
   input wire logic        serTxReady,
   input wire logic [7:0]  serTxData
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // bus answer timing and frame hand-off properties
   wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus not answered");
   wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer too long");
   rx_take_a: assert property (canRxValid && canRxReady |=> !canRxReady)
      else $error("frame ready held");
   dlc_range_a: assert property (canTxValid |-> canTxDlc != 4'h0 && canTxDlc <= 4'h8)
      else $error("bad length code");
   tx_hold_a: assert property (canTxValid && !canTxReady |=> canTxValid && $stable(canTxId))
      else $error("frame dropped");
   std_width_a: assert property (canTxValid && !canTxExt |-> canTxId[28:11] == 18'h0)
      else $error("wide standard id");
   ser_hold_a: assert property (serTxValid && !serTxReady |=> serTxValid && $stable(serTxData))
      else $error("serial byte lost");
   back_press_a: assert property (canTxValid |-> !serRxReady)
      else $error("serial taken while blocked");
endmodule : ucfb_bridge_checker
bind ucfb_bridge ucfb_bridge_checker mon (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .canRxValid,
   .canRxReady, .canTxValid, .canTxReady, .canTxExt, .canTxId, .canTxDlc, .serRxReady, .serTxValid,
   .serTxReady, .serTxData);
`default_nettype wire

// *** bench/ucfb_peer_model.sv ***
// far side: serial sink and bus peer, stalling in turn
`timescale 1ns/1ps
`default_nettype none
module ucfb_peer_model
(
   input wire logic clk,
   input wire logic rst,
   output logic     canTxReady,
   output logic     serTxReady
);
   logic [1:0] cntReg;
   // free count paces both acceptors
   always_ff @(posedge clk or posedge rst)
      if (rst) cntReg <= 2'h0;
      else cntReg <= cntReg + 2'h1;
   assign canTxReady = cntReg[0];
   assign serTxReady = cntReg != 2'h3;
endmodule : ucfb_peer_model
`default_nettype wire

// *** bench/ucfb_bridge_bench.sv ***
// bench of the filter and pair bridge
`timescale 1ns/1ps
`default_nettype none
module ucfb_bridge_bench;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sv = 1'b0, cv = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wd = 32'h0, rdat, rdo;
   logic [7:0] sd = 8'h00, sdo;
   logic [28:0] cid = 29'h0, tid;
   logic [3:0] tdl, cdl = 4'h1;
   logic [63:0] cdat = 64'h0, tdat;
   logic wq, srr, stv, str, crr, ctv, ctr, led, rsp;
   logic [7:0] sq[$];
   logic [96:0] fq[$];
   int badCount = 0, nChecks = 0, rsc = 0;
   ucfb_bridge #(.MS_CYCLES(10)) dut (.clk, .rst, .ce(1'b1), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdo), .avs_waitrequest(wq),
      .serRxValid(sv), .serRxData(sd), .serRxReady(srr), .serTxValid(stv), .serTxData(sdo), .serTxReady(str),
      .canRxValid(cv), .canRxId(cid), .canRxDlc(cdl), .canRxData(cdat), .canRxReady(crr), .canTxValid(ctv),
      .canTxId(tid), .canTxExt(), .canTxDlc(tdl), .canTxData(tdat), .canTxReady(ctr), .errLed(led),
      .restartPulse(rsp));
   ucfb_peer_model peer (.clk, .rst, .canTxReady(ctr), .serTxReady(str));
   initial forever #20 clk = ~clk;
   // capture bytes and frames leaving the bridge, unused data bytes masked
   always @(posedge clk)
   begin
      if (stv && str) sq.push_back(sdo);
      if (ctv && ctr) fq.push_back({tid, tdl, tdat & (~64'h0 >> (7'd64 - {tdl, 3'h0}))});
      if (rsp) rsc++;
   end
   task chk(input logic [96:0] g, e);
      nChecks++;
      if (g !== e)
      begin
         badCount++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task testDone;
      if (badCount == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : testDone
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do @(posedge clk); while (wq !== 1'b0);
      rdat = rdo;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task serIn(input logic [7:0] b);
      @(posedge clk);
      sv <= 1'b1;
      sd <= b;
      do @(posedge clk); while (srr !== 1'b1);
      sv <= 1'b0;
      sd <= ~b;
   endtask : serIn
   // one frame offered on the receive side, held until taken
   task canIn(input logic [28:0] i, input logic [3:0] l, input logic [63:0] d);
      @(posedge clk);
      cv <= 1'b1;
      cid <= i;
      cdl <= l;
      cdat <= d;
      do @(posedge clk); while (crr !== 1'b1);
      cv <= 1'b0;
      cdat <= ~d;
   endtask : canIn
   // one received frame under a given filter setting
   task flt(input logic [31:0] c, m, k, input logic [28:0] i, input logic p);
      int n;
      bus(1'b1, 5'h00, c);
      bus(1'b1, 5'h04, k);
      bus(1'b1, 5'h08, m);
      n = sq.size();
      canIn(i, 4'h1, {56'h0, i[7:0]});
      repeat (40) @(posedge clk);
      chk(sq.size(), n + p);
      if (p) chk(sq[n], i[7:0]);
   endtask : flt
   // register values after reset
   task regRst;
      bus(1'b0, 5'h00, 32'h0);
      chk(rdat, 32'h0);
      bus(1'b0, 5'h10, 32'h0);
      chk(rdat, 32'h0d0a);
      bus(1'b0, 5'h14, 32'h0);
      chk(rdat, 32'h0301);
      bus(1'b0, 5'h1c, 32'h0);
      chk(rdat, 32'h0);
   endtask : regRst
   // nine serial bytes under a fixed identifier
   task pairFix;
      bus(1'b1, 5'h0c, 32'h1);
      bus(1'b1, 5'h00, 32'h5);
      for (int b = 'h31; b < 'h3a; b++) serIn(b[7:0]);
      repeat (200) @(posedge clk);
      chk(fq.size(), 2);
      chk(fq[0], {29'h1, 4'h8, 64'h3837363534333231});
      chk(fq[1], {29'h1, 4'h1, 64'h39});
   endtask : pairFix
   // header chars give the id; prefix and terminator on the way back
   task pairDyn;
      int n, m;
      bus(1'b1, 5'h08, 32'h0);
      bus(1'b1, 5'h14, 32'h0314);
      bus(1'b1, 5'h00, 32'h19);
      n = sq.size();
      m = fq.size();
      serIn(8'h37);
      serIn(8'h61);
      serIn(8'h35);
      serIn(8'h41);
      repeat (60) @(posedge clk);
      chk(fq.size(), m + 1);
      chk(fq[m], {29'h7a5, 4'h1, 64'h41});
      canIn(29'h7a5, 4'h2, 64'h4241);
      repeat (20) @(posedge clk);
      chk(sq.size(), n);
      canIn(29'h7a5, 4'h1, 64'h0d);
      repeat (40) @(posedge clk);
      chk(sq.size(), n + 6);
      chk({sq[n], sq[n+1], sq[n+2], sq[n+3], sq[n+4], sq[n+5]}, 48'h374135_41420d);
   endtask : pairDyn
   // buffer overflow lights the lamp, then one restart
   task ovfErr;
      repeat (10) canIn(29'h1, 4'h8, 64'h0);
      repeat (2) @(posedge clk);
      chk(led, 1'b1);
      repeat (3100) @(posedge clk);
      chk({led, rsc[7:0]}, 9'h001);
   endtask : ovfErr
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      regRst;
      flt(32'h1, 32'h0, 32'h7ff, 29'h2a5, 1'b1);
      flt(32'h1, 32'h7ff, 32'h123, 29'h123, 1'b1);
      flt(32'h1, 32'h7ff, 32'h123, 29'h124, 1'b0);
      flt(32'h1, 32'h7c0, 32'h100, 29'h12f, 1'b1);
      flt(32'h1, 32'h7c0, 32'h100, 29'h140, 1'b0);
      flt(32'h1, 32'h7ff, 32'h123, 29'h1ffff923, 1'b1);
      flt(32'h3, 32'h1fffffff, 32'h1234567, 29'h1234567, 1'b1);
      flt(32'h3, 32'h1fffffff, 32'h1234567, 29'h1634567, 1'b0);
      pairFix;
      pairDyn;
      ovfErr;
      testDone;
   end
   // hang guard
   initial
   begin
      repeat (8000) @(posedge clk);
      badCount++;
      testDone;
   end
endmodule : ucfb_bridge_bench
`default_nettype wire
